// ==== hw/gtp_target.sv ====
// I2C target port of the gauge: byte engine, pointer, timeout, stretch
`timescale 1ns/10ps
module gtp_target
    import gtp_pkg::*;
#(
    parameter int BUS_TO_CYCLES  = BUS_TO_CYC,   // Stuck-bus timeout
    parameter int STRETCH_CYCLES = STRETCH_CYC,  // Longest clock stretch
    parameter int MAX_WR         = MAX_WR_BYTES  // Data bytes per write
)
(
    input  wire logic       clock_i,          // 200 MHz clock
    input  wire logic       rst_n_i,          // Sync reset, active low
    input  wire logic       scl_i,            // SCL pin level
    input  wire logic       sda_i,            // SDA pin level
    output logic            scl_o,            // SCL drive value, always low
    output logic            scl_oe_n_o,       // SCL driven while low
    output logic            sda_o,            // SDA drive value, always low
    output logic            sda_oe_n_o,       // SDA driven while low
    output logic [7:0]      loc_addr_o,       // Command location pointer
    output logic [7:0]      loc_wdata_o,      // Write data
    output logic            loc_wr_o,         // Write strobe, one cycle
    input  wire logic [7:0] loc_rdata_i,      // Data at loc_addr_o
    input  wire logic       loc_ro_i,         // Location at loc_addr_o is read-only
    input  wire logic       stretch_i,        // Hold SCL low (flash or sample busy)
    input  wire logic       single_wire_en_i, // Alternative interface selected
    output logic            i2c_active_o,     // I2C port in service
    output logic            sleep_o           // Engine asleep on stuck line
);
    if (MAX_WR < 1 || MAX_WR > 3)
        $error("MAX_WR must be 1 to 3");
    if (BUS_TO_CYCLES <= SETTLE_CYC || STRETCH_CYCLES < 1)
        $error("Timeout or stretch count too small");

    gtp_line_if ln();
    gtp_top_t   r;
    gtp_top_t   n;
    logic       bus_low;
    logic       busy;

    gtp_line_sync u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .lines   (ln)
    );

    assign bus_low = !ln.scl || !ln.sda;
    assign busy    = r.st inside {ST_ADDR, ST_CMD, ST_WDATA, ST_ACK,
                                  ST_RDATA, ST_RACK, ST_RLOAD};

    always_comb
    begin
        n        = r;
        n.wr     = 1'b0;
        n.active = !single_wire_en_i;
        if (r.st == ST_STUCK || (bus_low && r.st != ST_SLEEP))
            n.to_cnt = r.to_cnt + 32'h0000_0001;
        else
            n.to_cnt = '0;
        // Stretch only a low SCL, and never past the longest allowed time
        if (stretch_i && busy && !ln.scl && r.str_cnt < 32'(STRETCH_CYCLES))
        begin
            n.scl_oe_n = 1'b0;
            n.str_cnt  = r.str_cnt + 32'h0000_0001;
        end
        else
        begin
            n.scl_oe_n = 1'b1;
            if (!stretch_i)
                n.str_cnt = '0;
        end

        case (r.st)
            ST_ADDR, ST_CMD, ST_WDATA:
            begin
                if (ln.scl_rise)
                begin
                    n.rx  = {r.rx[6:0], ln.sda};
                    n.cnt = r.cnt + 4'h1;
                end
                if (ln.scl_fall && r.cnt == BITS_BYTE)
                begin
                    n.cnt = '0;
                    n.st  = ST_WAIT;
                    n.inc = 1'b0;
                    if (r.st == ST_ADDR && r.rx[7:1] == DEV_ADDR)
                    begin
                        n.sda_oe_n = 1'b0;
                        n.st       = ST_ACK;
                        n.ret      = r.rx[0] ? ST_RDATA : ST_CMD;
                    end
                    else if (r.st == ST_CMD && r.rx <= CMD_MAX_RD)
                    begin
                        n.ptr      = r.rx;
                        n.wcnt     = '0;
                        n.sda_oe_n = 1'b0;
                        n.st       = ST_ACK;
                        n.ret      = ST_WDATA;
                    end
                    else if (r.st == ST_WDATA && !loc_ro_i
                             && r.wcnt != 2'(MAX_WR))
                    begin
                        n.wr       = 1'b1;
                        n.wdata    = r.rx;
                        n.wcnt     = r.wcnt + 2'h1;
                        n.inc      = 1'b1;
                        n.sda_oe_n = 1'b0;
                        n.st       = ST_ACK;
                        n.ret      = ST_WDATA;
                    end
                end
            end
            ST_ACK:
            begin
                if (ln.scl_fall)
                begin
                    n.sda_oe_n = 1'b1;
                    n.st       = r.ret;
                    if (r.inc)
                        n.ptr = r.ptr + PTR_STEP;
                    if (r.ret == ST_RDATA)
                    begin
                        n.sda_oe_n = loc_rdata_i[7];
                        n.tx       = {loc_rdata_i[6:0], 1'b0};
                    end
                end
            end
            ST_RDATA:
            begin
                if (ln.scl_rise)
                    n.cnt = r.cnt + 4'h1;
                if (ln.scl_fall)
                begin
                    if (r.cnt == BITS_BYTE)
                    begin
                        n.sda_oe_n = 1'b1;
                        n.cnt      = '0;
                        n.st       = ST_RACK;
                    end
                    else
                    begin
                        n.sda_oe_n = r.tx[7];
                        n.tx       = {r.tx[6:0], 1'b0};
                    end
                end
            end
            ST_RACK:
            begin
                // A host NACK ends the read; only stop or start follows
                if (ln.scl_rise)
                begin
                    n.st = ln.sda ? ST_WAIT : ST_RLOAD;
                    if (!ln.sda)
                        n.ptr = r.ptr + PTR_STEP;
                end
            end
            ST_RLOAD:
            begin
                if (ln.scl_fall)
                begin
                    n.sda_oe_n = loc_rdata_i[7];
                    n.tx       = {loc_rdata_i[6:0], 1'b0};
                    n.st       = ST_RDATA;
                end
            end
            ST_STUCK:
            begin
                // Released lines need the synchroniser delay before judging
                n.sda_oe_n = 1'b1;
                n.scl_oe_n = 1'b1;
                if (r.to_cnt == 32'(SETTLE_CYC - 1))
                begin
                    n.st    = bus_low ? ST_SLEEP : ST_IDLE;
                    n.sleep = bus_low;
                end
            end
            ST_SLEEP:
            begin
                n.scl_oe_n = 1'b1;
                if (!bus_low)
                begin
                    n.st    = ST_IDLE;
                    n.sleep = 1'b0;
                end
            end
            default:
            begin
                n.sda_oe_n = 1'b1;
            end
        endcase

        if (r.st != ST_STUCK && r.st != ST_SLEEP)
        begin
            if (ln.start)
            begin
                n.st       = ST_ADDR;
                n.cnt      = '0;
                n.sda_oe_n = 1'b1;
            end
            else if (ln.stop)
            begin
                n.st       = ST_IDLE;
                n.sda_oe_n = 1'b1;
            end
            if (r.to_cnt == 32'(BUS_TO_CYCLES - 1))
            begin
                n.st       = ST_STUCK;
                n.to_cnt   = '0;
                n.sda_oe_n = 1'b1;
                n.scl_oe_n = 1'b1;
            end
        end
        if (!r.active)
        begin
            n.st       = ST_IDLE;
            n.sda_oe_n = 1'b1;
            n.scl_oe_n = 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            r <= '{st: ST_IDLE, ret: ST_IDLE, sda_oe_n: 1'b1, scl_oe_n: 1'b1,
                   active: 1'b1, default: '0};
        else
            r <= n;
    end

    assign scl_o        = r.line_out;
    assign sda_o        = r.line_out;
    assign scl_oe_n_o   = r.scl_oe_n;
    assign sda_oe_n_o   = r.sda_oe_n;
    assign loc_addr_o   = r.ptr;
    assign loc_wdata_o  = r.wdata;
    assign loc_wr_o     = r.wr;
    assign i2c_active_o = r.active;
    assign sleep_o      = r.sleep;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    addr_match_a: assert property ((r.st == ST_ADDR && ln.scl_fall && r.cnt == BITS_BYTE
        && !ln.start && !ln.stop && r.active && r.to_cnt != 32'(BUS_TO_CYCLES - 1))
        |=> (r.sda_oe_n == ($past(r.rx[7:1]) != DEV_ADDR)))
        else $error("address acknowledge wrong");
    quick_read_a: assert property ((r.st == ST_ACK && ln.scl_fall && r.ret == ST_RDATA
        && !ln.start && !ln.stop && r.active && r.to_cnt != 32'(BUS_TO_CYCLES - 1))
        |=> (r.sda_oe_n == $past(loc_rdata_i[7])) && r.st == ST_RDATA)
        else $error("quick read first bit wrong");
    ptr_advance_a: assert property ((r.st == ST_RACK && ln.scl_rise && !ln.sda
        && !ln.start && !ln.stop && r.active && r.to_cnt != 32'(BUS_TO_CYCLES - 1))
        |=> r.ptr == $past(r.ptr) + PTR_STEP)
        else $error("pointer did not advance on host ack");
    write_step_a: assert property ((r.st == ST_ACK && r.inc && ln.scl_fall
        && !ln.start && !ln.stop && r.active && r.to_cnt != 32'(BUS_TO_CYCLES - 1))
        |=> r.ptr == $past(r.ptr) + PTR_STEP)
        else $error("write pointer did not advance");
    wr_ack_a: assert property ((r.st == ST_WDATA && ln.scl_fall && r.cnt == BITS_BYTE
        && !loc_ro_i && r.wcnt != 2'(MAX_WR) && !ln.start && !ln.stop && r.active
        && r.to_cnt != 32'(BUS_TO_CYCLES - 1))
        |=> r.wr && !r.sda_oe_n && r.st == ST_ACK)
        else $error("stored byte not acknowledged");
    ro_nack_a: assert property ((r.st == ST_WDATA && ln.scl_fall && r.cnt == BITS_BYTE
        && loc_ro_i) |=> !r.wr && r.sda_oe_n)
        else $error("read-only write acknowledged");
    cmd_nack_a: assert property ((r.st == ST_CMD && ln.scl_fall && r.cnt == BITS_BYTE
        && r.rx > CMD_MAX_RD) |=> r.sda_oe_n && !r.wr)
        else $error("high command acknowledged");
    wr_limit_a: assert property ((r.st == ST_WDATA && ln.scl_fall && r.cnt == BITS_BYTE
        && r.wcnt == 2'(MAX_WR)) |=> !r.wr && r.sda_oe_n)
        else $error("extra write byte acknowledged");
    bus_release_a: assert property ((r.to_cnt == 32'(BUS_TO_CYCLES - 1) && r.active
        && r.st != ST_STUCK && r.st != ST_SLEEP)
        |=> r.sda_oe_n && r.scl_oe_n && r.st == ST_STUCK)
        else $error("stuck bus not released");
    stuck_sleep_a: assert property ((r.st == ST_STUCK && r.to_cnt == 32'(SETTLE_CYC - 1)
        && bus_low && r.active) |=> sleep_o && r.st == ST_SLEEP)
        else $error("no sleep on held line");
    stretch_cap_a: assert property ((r.str_cnt >= 32'(STRETCH_CYCLES))
        |=> r.scl_oe_n)
        else $error("stretch beyond limit");
    port_active_a: assert property (single_wire_en_i |=> !i2c_active_o
        ##1 (r.sda_oe_n && r.scl_oe_n))
        else $error("port active while single-wire selected");

    write_c: cover property (r.wr ##[1:400] r.wr);
    incr_read_c: cover property (r.st == ST_RLOAD ##[1:400] r.st == ST_RLOAD);
    sleep_c: cover property ($rose(r.sleep));

endmodule : gtp_target

// ==== hw/gtp_pkg.sv ====
// Shared constants and types of the gauge I2C target port
package gtp_pkg;

    localparam int          CLK_HZ           = 200_000_000;
    localparam int          CYC_PER_MS       = CLK_HZ / 1000;
    localparam int          BUS_TO_MS        = 2000;
    localparam int          BUS_TO_CYC       = BUS_TO_MS * CYC_PER_MS;
    localparam int          FLASH_STRETCH_MS = 80;
    localparam int          OCV_STRETCH_MS   = 270;
    localparam int          STRETCH_CYC      = OCV_STRETCH_MS * CYC_PER_MS;
    localparam int          SETTLE_CYC       = 8;
    localparam int          MAX_WR_BYTES     = 2;
    localparam logic [6:0]  DEV_ADDR         = 7'h55;
    localparam logic [7:0]  CMD_MAX_RD       = 8'h7F;
    localparam logic [3:0]  BITS_BYTE        = 4'h8;
    localparam logic [7:0]  PTR_STEP         = 8'h01;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA,
        ST_RACK, ST_RLOAD, ST_WAIT, ST_STUCK, ST_SLEEP
    } gtp_state_t;

    typedef struct packed {
        gtp_state_t st;
        gtp_state_t ret;
        logic       inc;
        logic [3:0] cnt;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic [1:0] wcnt;
        logic [7:0] wdata;
        logic       wr;
        logic       sda_oe_n;
        logic       scl_oe_n;
        logic       line_out;
        logic [31:0] to_cnt;
        logic [31:0] str_cnt;
        logic       sleep;
        logic       active;
    } gtp_top_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] st;
        logic       rise;
        logic       fall;
        logic       start;
        logic       stop;
    } gtp_sync_t;

endpackage : gtp_pkg

// ==== hw/gtp_line_if.sv ====
// Conditioned bus lines and bus events
`timescale 1ns/10ps
interface gtp_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    modport src (output scl, sda, scl_rise, scl_fall, start, stop);
    modport dst (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface : gtp_line_if

// ==== hw/gtp_line_sync.sv ====
// Pin synchroniser and start/stop/edge detector
`timescale 1ns/10ps
module gtp_line_sync
    import gtp_pkg::*;
(
    input  wire logic clock_i,   // 200 MHz clock
    input  wire logic rst_n_i,   // Sync reset, active low
    input  wire logic scl_i,     // SCL pin level
    input  wire logic sda_i,     // SDA pin level
    gtp_line_if.src   lines      // Conditioned lines and events
);
    gtp_sync_t r;
    gtp_sync_t n;

    always_comb
    begin
        n       = r;
        n.s1    = {scl_i, sda_i};
        n.s2    = r.s1;
        n.s3    = r.s2;
        // A level counts only once the two later stages agree
        for (int i = 0; i < 2; i++)
        begin
            if (r.s2[i] == r.s3[i])
                n.st[i] = r.s3[i];
        end
        n.rise  = n.st[1] & ~r.st[1];
        n.fall  = ~n.st[1] & r.st[1];
        n.start = r.st[1] & n.st[1] & r.st[0] & ~n.st[0];
        n.stop  = r.st[1] & n.st[1] & ~r.st[0] & n.st[0];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            r <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, st: 2'h3, default: '0};
        else
            r <= n;
    end

    assign lines.scl      = r.st[1];
    assign lines.sda      = r.st[0];
    assign lines.scl_rise = r.rise;
    assign lines.scl_fall = r.fall;
    assign lines.start    = r.start;
    assign lines.stop     = r.stop;

endmodule : gtp_line_sync

// ==== testbench/gtp_host_model.sv ====
// Host controller model for the two-wire bus, open-drain with pull-ups
`timescale 1ns/10ps
module gtp_host_model
#(
    parameter int Q_CYC = 10  // Quarter bit time in clock cycles
)
(
    input  wire logic clock_i,  // Bench clock
    input  wire logic scl_i,    // SCL wire level
    input  wire logic sda_i,    // SDA wire level
    output logic      scl_o,    // Host SCL drive, 1 releases
    output logic      sda_o     // Host SDA drive, 1 releases
);
    int max_wait;

    initial
    begin
        scl_o    = 1'b1;
        sda_o    = 1'b1;
        max_wait = 0;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge clock_i);
    endtask : hold

    task automatic drive(input logic c, input logic d);
        scl_o = c;
        sda_o = d;
    endtask : drive

    // Data only moves while SCL is low; target stretch is waited out
    task automatic bit_xfer(input logic b, output logic r);
        int w;
        w = 0;
        hold(Q_CYC);
        sda_o = b;
        hold(Q_CYC);
        scl_o = 1'b1;
        hold(1);
        while (scl_i !== 1'b1 && w < 1000)
        begin
            hold(1);
            w++;
        end
        if (w > max_wait)
            max_wait = w;
        hold(Q_CYC);
        r = sda_i;
        hold(Q_CYC);
        scl_o = 1'b0;
    endtask : bit_xfer

    // Serves as start and as repeated start
    task automatic start;
        hold(Q_CYC);
        sda_o = 1'b1;
        hold(Q_CYC);
        scl_o = 1'b1;
        hold(Q_CYC);
        sda_o = 1'b0;
        hold(Q_CYC);
        scl_o = 1'b0;
    endtask : start

    task automatic stop;
        hold(Q_CYC);
        sda_o = 1'b0;
        hold(Q_CYC);
        scl_o = 1'b1;
        hold(Q_CYC);
        sda_o = 1'b1;
        hold(Q_CYC);
    endtask : stop

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(b[i], r);
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, b[i]);
        bit_xfer(last, r);
    endtask : rd_byte

endmodule : gtp_host_model

// ==== testbench/gauge_i2c_target_port_test.sv ====
// Self-checking bench of the gauge target port against a host model
`timescale 1ns/10ps
`define CHECK(name, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            $display("ERROR %s expected %h seen %h", name, exp, got); \
            failures++; \
        end \
    end
module gauge_i2c_target_port_test
    import gtp_pkg::*;
;
    localparam int TO_CYC  = 2000;
    localparam int STR_CYC = 200;
    localparam int GAP_CYC = 13200;  // 66 us pacing
    localparam int WD_CYC  = 80000;

    logic       clock_i;
    logic       rst_n_i;
    logic       host_scl;
    logic       host_sda;
    logic       scl_w;
    logic       sda_w;
    logic       dut_scl;
    logic       dut_scl_oe_n;
    logic       dut_sda;
    logic       dut_sda_oe_n;
    logic [7:0] loc_addr;
    logic [7:0] loc_wdata;
    logic       loc_wr;
    logic [7:0] loc_rdata;
    logic       loc_ro;
    logic       stretch;
    logic       single_wire_en;
    logic       i2c_active;
    logic       sleep;
    logic [7:0] mem [256];
    logic       ro  [256];
    int         failures;
    int         cmp_count;

    function automatic logic [7:0] init_val(input logic [7:0] a);
        return a ^ 8'hA5;
    endfunction : init_val

    always #2.5 clock_i = ~clock_i;

    // Wired-AND of host, target and pull-up
    assign scl_w     = host_scl & (dut_scl_oe_n ? 1'b1 : dut_scl);
    assign sda_w     = host_sda & (dut_sda_oe_n ? 1'b1 : dut_sda);
    assign loc_rdata = mem[loc_addr];
    assign loc_ro    = ro[loc_addr];

    always @(posedge clock_i)
        if (loc_wr)
            mem[loc_addr] <= loc_wdata;

    gtp_host_model i_host (.clock_i(clock_i), .scl_i(scl_w), .sda_i(sda_w),
                           .scl_o(host_scl), .sda_o(host_sda));

    // Write limit stays at its default of two bytes
    gtp_target #(.BUS_TO_CYCLES(TO_CYC), .STRETCH_CYCLES(STR_CYC)) i_dut (
        .clock_i          (clock_i),
        .rst_n_i          (rst_n_i),
        .scl_i            (scl_w),
        .sda_i            (sda_w),
        .scl_o            (dut_scl),
        .scl_oe_n_o       (dut_scl_oe_n),
        .sda_o            (dut_sda),
        .sda_oe_n_o       (dut_sda_oe_n),
        .loc_addr_o       (loc_addr),
        .loc_wdata_o      (loc_wdata),
        .loc_wr_o         (loc_wr),
        .loc_rdata_i      (loc_rdata),
        .loc_ro_i         (loc_ro),
        .stretch_i        (stretch),
        .single_wire_en_i (single_wire_en),
        .i2c_active_o     (i2c_active),
        .sleep_o          (sleep)
    );

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    // acks: address, command, then one bit per data byte
    task automatic wr_xfer(input logic [7:0] cmd, input logic [23:0] d, input int n,
                           output logic [4:0] acks);
        logic a;
        acks = 5'h00;
        i_host.start();
        i_host.wr_byte(8'hAA, a);
        acks[0] = a;
        i_host.wr_byte(cmd, a);
        acks[1] = a;
        for (int i = 0; i < n; i++)
        begin
            i_host.wr_byte(d[23-8*i -: 8], a);
            acks[2+i] = a;
        end
        i_host.stop();
        i_host.hold(8); // Plain location writes await no result
    endtask : wr_xfer

    task automatic t_write;
        logic [4:0] k;
        `CHECK("port active", 1'b1, i2c_active);
        wr_xfer(8'h10, 24'hC3_0000, 1, k);
        `CHECK("one-byte write acks", 3'b111, k[2:0]);
        `CHECK("stored byte", 8'hC3, mem[8'h10]);
        `CHECK("pointer after write", 8'h11, loc_addr);
        wr_xfer(8'h20, 24'hA1_B2C3, 3, k);
        `CHECK("extra byte refused", 5'b01111, k);
        `CHECK("first of two", 8'hA1, mem[8'h20]);
        `CHECK("second of two", 8'hB2, mem[8'h21]);
        `CHECK("extra not stored", init_val(8'h22), mem[8'h22]);
        ro[8'h30] = 1'b1;
        wr_xfer(8'h30, 24'h77_0000, 1, k);
        ro[8'h30] = 1'b0;
        `CHECK("read-only refused", 3'b011, k[2:0]);
        `CHECK("read-only kept", init_val(8'h30), mem[8'h30]);
        wr_xfer(8'h80, 24'h00_0000, 0, k);
        `CHECK("command above range", 2'b01, k[1:0]);
        wr_xfer(8'h7F, 24'h00_0000, 0, k);
        `CHECK("top command", 2'b11, k[1:0]);
        $display("test write done");
    endtask : t_write

    task automatic t_read;
        logic       a;
        logic [7:0] q;
        logic [7:0] bad [3];
        bad = '{8'hA8, 8'hAC, 8'h2A};
        foreach (bad[i])
        begin
            i_host.start();
            i_host.wr_byte(bad[i], a);
            i_host.stop();
            `CHECK("foreign address", 1'b0, a);
        end
        i_host.start();
        i_host.wr_byte(8'hAA, a);
        i_host.wr_byte(8'h40, a);
        i_host.start();
        i_host.wr_byte(8'hAB, a);
        `CHECK("read address ack", 1'b1, a);
        for (int i = 0; i < 3; i++)
        begin
            i_host.rd_byte(i == 2, q);
            `CHECK("incremental byte", init_val(8'h40 + 8'(i)), q);
        end
        i_host.stop();
        i_host.hold(8);
        `CHECK("pointer after read", 8'h42, loc_addr);
        i_host.hold(GAP_CYC);
        i_host.start();
        i_host.wr_byte(8'hAB, a);
        i_host.rd_byte(1'b1, q);
        i_host.stop();
        `CHECK("quick read byte", init_val(8'h42), q);
        $display("test read done");
    endtask : t_read

    task automatic t_stretch;
        logic [4:0] k;
        i_host.max_wait = 0;
        stretch = 1'b1;
        wr_xfer(8'h50, 24'h3C_0000, 1, k);
        stretch = 1'b0;
        `CHECK("stretched write acks", 3'b111, k[2:0]);
        `CHECK("stretched byte", 8'h3C, mem[8'h50]);
        `CHECK("stretch bounded", 1'b1, 1'(i_host.max_wait inside {[100:STR_CYC+10]}));
        $display("test stretch done");
    endtask : t_stretch

    task automatic t_timeout;
        logic r;
        i_host.start();
        for (int i = 7; i >= 0; i--)
            i_host.bit_xfer(1'(8'hAA >> i), r);
        i_host.hold(10);
        `CHECK("target holds ack", 1'b0, dut_sda_oe_n);
        i_host.drive(1'b1, 1'b1);
        i_host.hold(TO_CYC + SETTLE_CYC + 20);
        `CHECK("data line released", 1'b1, dut_sda_oe_n);
        `CHECK("no sleep when free", 1'b0, sleep);
        i_host.start();
        i_host.hold(TO_CYC + SETTLE_CYC + 20);
        `CHECK("sleep on held line", 1'b1, sleep);
        `CHECK("clock released", 1'b1, dut_scl_oe_n);
        i_host.drive(1'b1, 1'b1);
        i_host.hold(10);
        `CHECK("wake when free", 1'b0, sleep);
        $display("test timeout done");
    endtask : t_timeout

    task automatic t_single_wire;
        logic a;
        single_wire_en = 1'b1;
        i_host.hold(4);
        `CHECK("port inactive", 1'b0, i2c_active);
        i_host.start();
        i_host.wr_byte(8'hAA, a);
        i_host.stop();
        `CHECK("ignored when inactive", 1'b0, a);
        single_wire_en = 1'b0;
        i_host.hold(4);
        `CHECK("port back", 1'b1, i2c_active);
        $display("test single wire done");
    endtask : t_single_wire

    initial
    begin
        clock_i        = 1'b0;
        rst_n_i        = 1'b0;
        stretch        = 1'b0;
        single_wire_en = 1'b0;
        failures       = 0;
        cmp_count      = 0;
        for (int i = 0; i < 256; i++)
        begin
            mem[i] = init_val(8'(i));
            ro[i]  = 1'b0;
        end
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'b1;
        i_host.hold(10);
        t_write();
        t_read();
        t_stretch();
        t_timeout();
        t_single_wire();
        end_sim();
    end

    // Run needs roughly 30000 cycles
    initial
    begin
        repeat (WD_CYC) @(posedge clock_i);
        failures++;
        end_sim();
    end

endmodule : gauge_i2c_target_port_test
